// ### include/abct_pkg.sv
/*
  abct_pkg: shared constants for the bank cycle-timing block.
  Assumes a 25 MHz bus clock and four independently configured memory banks.
*/
`default_nettype none
package abct_pkg;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BUS_CLK_PERIOD_PS = 40000;
  localparam logic [31:0] BUS_PS = 32'h0000_9c40;
  localparam logic [31:0] WR_REC_MAX_PS = 32'h0004_e200;
  // memory kinds
  localparam logic [2:0] KIND_SYNC_SRAM = 3'h0;
  localparam logic [2:0] KIND_ASYNC_SRAM = 3'h1;
  localparam logic [2:0] KIND_LIN_FLASH = 3'h2;
  localparam logic [2:0] KIND_PAGE_FLASH = 3'h3;
  localparam logic [2:0] KIND_PSRAM = 3'h4;
  // per-bank register window
  localparam logic [11:0] BANK_STRIDE = 12'h040;
  localparam logic [5:0] OFF_CFG = 6'h00;
  localparam logic [5:0] OFF_TIME0 = 6'h04;
  localparam logic [5:0] OFF_MEMCFG = 6'h30;
  localparam logic [5:0] OFF_DERIVED = 6'h34;
  localparam int unsigned NUM_TIMES = 11;
  localparam int unsigned T_CE_DV = 0;
  localparam int unsigned T_AV_DV = 1;
  localparam int unsigned T_CE_HZ = 2;
  localparam int unsigned T_OE_HZ = 3;
  localparam int unsigned T_PAGE = 4;
  localparam int unsigned T_WC = 5;
  localparam int unsigned T_WP = 6;
  localparam int unsigned T_WE_LZ = 7;
  localparam int unsigned T_WR_REC = 8;
  localparam int unsigned T_WIN_LO = 9;
  localparam int unsigned T_WIN_HI = 10;
  // global registers
  localparam logic [11:0] OFF_GCTRL = 12'h100;
  localparam logic [11:0] OFF_FLASH_PER = 12'h104;
  localparam logic [11:0] OFF_GSTAT = 12'h108;
  // bank cfg fields
  localparam int unsigned CFG_KIND_LSB = 0;
  localparam int unsigned CFG_LAT_LSB = 4;
  localparam int unsigned CFG_PARITY_BIT = 8;
  localparam int unsigned CFG_WIDTH_LSB = 12;
  localparam logic [15:0] CFG_RESET = 16'h2001;
  localparam logic [31:0] FLASH_PER_RESET = 32'h0001_3880;
  // gstat fields
  localparam int unsigned GS_WIN_ERR_LSB = 0;
  localparam int unsigned GS_RATIO_ERR = 4;
  localparam int unsigned GS_NEG_WARN = 5;
  localparam int unsigned GS_REC_ERR = 6;
  localparam int unsigned GS_MAXW_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_GAP = 2'h1,
    ST_ACT = 2'h3,
    ST_REC = 2'h2
  } abct_state_t;
endpackage
`default_nettype wire

// ### rtl/abct_bank_timing.sv
/*
  abct_bank_timing: per-bank configuration registers over AXI4-Lite, picosecond to
  cycle conversion, bank window decode and a single-access cycle sequencer.
  Assumes one 25 MHz clock, synchronous active-low reset, and a requester
  that holds no request while busy is high.
*/
// Implementation choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module abct_bank_timing #(
  parameter bit MEMCFG_PORT_EN = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // access requests
  input wire logic xfer_req,
  input wire logic xfer_write,
  input wire logic [31:0] xfer_addr,
  output logic xfer_busy,
  output logic xfer_done,
  output logic xfer_miss,
  // memory strobes, active high
  output logic [3:0] bank_ce,
  output logic bank_oe,
  output logic bank_we,
  // per-bank parity enables and global options
  output logic [3:0] parity_check_en,
  output logic falling_edge_io_flops,
  output logic flash_clk,
  // memory config port
  output logic [3:0] memcfg_strobe,
  output logic [31:0] memcfg_data
);
  localparam int unsigned NB = abct_pkg::NUM_BANKS;
  localparam int unsigned NT = abct_pkg::NUM_TIMES;

  typedef struct packed {
    logic aw_full, w_full, bvalid, rvalid;
    logic awrdy, wrdy, ardy, busy;
    logic [11:0] aw_addr;
    logic [31:0] w_data, rdata, flash_per, fdiv, mdata;
    logic [3:0] w_strb, ce, par, mstb;
    logic [1:0] bresp, rresp, bank, last_bank;
    logic [NB-1:0][15:0] cfg;
    logic [NB-1:0][NT-1:0][31:0] tm;
    logic [7:0] gctrl, cnt, act_len;
    abct_pkg::abct_state_t st;
    logic wr, last_valid, last_wr, done, miss, oe, we, neg, fclk;
    logic [27:0] last_page;
  } abct_regs_t;

  abct_regs_t q, d;

  function automatic logic [7:0] ps2cyc(input logic [31:0] ps);
    logic [32:0] num;
    logic [32:0] cyc;
    num = {1'b0, ps} + {1'b0, abct_pkg::BUS_PS} - 33'h1;
    cyc = num / {1'b0, abct_pkg::BUS_PS};
    ps2cyc = (cyc > 33'hff) ? 8'hff : cyc[7:0];
  endfunction

  function automatic logic [31:0] pmax(input logic [31:0] a, input logic [31:0] b);
    pmax = (a > b) ? a : b;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // per-bank derived timing
  logic [NB-1:0][2:0] kind;
  logic [NB-1:0][7:0] rd_cyc, pg_cyc, wr_cyc, r2w_cyc, w2r_cyc, rec_cyc;
  logic [NB-1:0] win_ok, win_hit, rec_err, sync_bank;
  logic [NB-1:0][1:0] wcode;

  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_bank
      logic [31:0] span;
      logic [31:0] rec_ps;
      assign kind[gb] = q.cfg[gb][abct_pkg::CFG_KIND_LSB +: 3];
      assign wcode[gb] = q.cfg[gb][abct_pkg::CFG_WIDTH_LSB +: 2];
      assign sync_bank[gb] = kind[gb] == abct_pkg::KIND_SYNC_SRAM;
      assign rd_cyc[gb] = sync_bank[gb]
        ? {5'h0, q.cfg[gb][abct_pkg::CFG_LAT_LSB +: 3]} + 8'h1
        : ps2cyc(pmax(q.tm[gb][abct_pkg::T_CE_DV], q.tm[gb][abct_pkg::T_AV_DV]));
      assign pg_cyc[gb] = (kind[gb] == abct_pkg::KIND_PAGE_FLASH)
        ? ps2cyc(q.tm[gb][abct_pkg::T_PAGE]) : rd_cyc[gb];
      assign wr_cyc[gb] = sync_bank[gb] ? 8'h1
        : ps2cyc(pmax(q.tm[gb][abct_pkg::T_WC], q.tm[gb][abct_pkg::T_WP]));
      assign r2w_cyc[gb] = sync_bank[gb] ? 8'h0
        : ps2cyc(pmax(q.tm[gb][abct_pkg::T_CE_HZ], q.tm[gb][abct_pkg::T_OE_HZ]));
      assign w2r_cyc[gb] = sync_bank[gb] ? 8'h0
        : ps2cyc(q.tm[gb][abct_pkg::T_WE_LZ]);
      assign rec_err[gb] = q.tm[gb][abct_pkg::T_WR_REC] > abct_pkg::WR_REC_MAX_PS;
      assign rec_ps = rec_err[gb] ? abct_pkg::WR_REC_MAX_PS : q.tm[gb][abct_pkg::T_WR_REC];
      assign rec_cyc[gb] = (kind[gb] == abct_pkg::KIND_LIN_FLASH ||
                            kind[gb] == abct_pkg::KIND_PAGE_FLASH) ? ps2cyc(rec_ps) : 8'h0;
      assign span = q.tm[gb][abct_pkg::T_WIN_HI] - q.tm[gb][abct_pkg::T_WIN_LO];
      // an unset high bound reads as zero and disables the bank
      assign win_ok[gb] = (q.tm[gb][abct_pkg::T_WIN_HI] != 32'h0) &&
        (q.tm[gb][abct_pkg::T_WIN_HI] > q.tm[gb][abct_pkg::T_WIN_LO]) &&
        ((span & (span + 32'h1)) == 32'h0);
      assign win_hit[gb] = win_ok[gb] && (xfer_addr >= q.tm[gb][abct_pkg::T_WIN_LO]) &&
        (xfer_addr <= q.tm[gb][abct_pkg::T_WIN_HI]);
    end
  endgenerate

  logic [1:0] max_wcode;
  logic hit_any;
  logic [1:0] hit_idx;
  logic ratio_ok;
  logic [31:0] ratio;
  always_comb begin
    max_wcode = 2'h0;
    hit_any = 1'b0;
    hit_idx = 2'h0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (wcode[i] > max_wcode) begin
        max_wcode = wcode[i];
      end
      if (win_hit[i]) begin
        hit_any = 1'b1;
        hit_idx = 2'(i);
      end
    end
  end
  assign ratio = q.flash_per / abct_pkg::BUS_PS;
  assign ratio_ok = (q.flash_per != 32'h0) &&
    (q.flash_per % abct_pkg::BUS_PS == 32'h0);

  logic [31:0] gstat;
  assign gstat = {8'h0, ratio[7:0], 6'h0, max_wcode, 1'b0, |rec_err,
                  q.gctrl[0] & ~|sync_bank, ~ratio_ok, ~win_ok};

  // register read decode, used by the read channel
  function automatic logic [33:0] rd_decode(input logic [11:0] a, input abct_regs_t s);
    logic [1:0] b;
    logic [5:0] o;
    b = a[7:6];
    o = a[5:0];
    rd_decode = {abct_pkg::RESP_SLVERR, 32'h0};
    if (a[11:8] == 4'h0) begin
      if (o == abct_pkg::OFF_CFG) begin
        rd_decode = {abct_pkg::RESP_OKAY, 16'h0, s.cfg[b]};
      end else if (o >= abct_pkg::OFF_TIME0 && o < abct_pkg::OFF_MEMCFG && o[1:0] == 2'h0) begin
        rd_decode = {abct_pkg::RESP_OKAY, s.tm[b][4'(o[5:2] - 4'h1)]};
      end else if (o == abct_pkg::OFF_MEMCFG) begin
        rd_decode = {abct_pkg::RESP_OKAY, 32'h0};
      end else if (o == abct_pkg::OFF_DERIVED) begin
        rd_decode = {abct_pkg::RESP_OKAY, rd_cyc[b], wr_cyc[b], r2w_cyc[b], w2r_cyc[b]};
      end
    end else if (a == abct_pkg::OFF_GCTRL) begin
      rd_decode = {abct_pkg::RESP_OKAY, 24'h0, s.gctrl};
    end else if (a == abct_pkg::OFF_FLASH_PER) begin
      rd_decode = {abct_pkg::RESP_OKAY, s.flash_per};
    end else if (a == abct_pkg::OFF_GSTAT) begin
      rd_decode = {abct_pkg::RESP_OKAY, gstat};
    end
  endfunction

  logic [1:0] wb;
  logic [5:0] wo;
  logic [7:0] len, gap;
  always_comb begin
    d = q;
    wb = q.aw_addr[7:6];
    wo = q.aw_addr[5:0];
    len = 8'h0;
    gap = 8'h0;
    d.done = 1'b0;
    d.miss = 1'b0;
    d.mstb = 4'h0;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && !q.aw_full && !q.bvalid) begin
      d.aw_full = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_full && !q.bvalid) begin
      d.w_full = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.aw_full && q.w_full) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = abct_pkg::RESP_OKAY;
      if (q.aw_addr[11:8] == 4'h0 && wo == abct_pkg::OFF_CFG) begin
        d.cfg[wb] = 16'(merge({16'h0, q.cfg[wb]}, q.w_data, q.w_strb));
      end else if (q.aw_addr[11:8] == 4'h0 && wo >= abct_pkg::OFF_TIME0 &&
                   wo < abct_pkg::OFF_MEMCFG && wo[1:0] == 2'h0) begin
        d.tm[wb][4'(wo[5:2] - 4'h1)] = merge(q.tm[wb][4'(wo[5:2] - 4'h1)], q.w_data, q.w_strb);
      end else if (q.aw_addr[11:8] == 4'h0 && wo == abct_pkg::OFF_MEMCFG) begin
        if (kind[wb] == abct_pkg::KIND_SYNC_SRAM || kind[wb] == abct_pkg::KIND_ASYNC_SRAM ||
            kind[wb] == abct_pkg::KIND_PSRAM) begin
          d.mstb[wb] = MEMCFG_PORT_EN;
          d.mdata = MEMCFG_PORT_EN ? q.w_data : 32'h0;
        end
      end else if (q.aw_addr == abct_pkg::OFF_GCTRL) begin
        d.gctrl = 8'(merge({24'h0, q.gctrl}, q.w_data, q.w_strb));
      end else if (q.aw_addr == abct_pkg::OFF_FLASH_PER) begin
        d.flash_per = merge(q.flash_per, q.w_data, q.w_strb);
      end else if (!(q.aw_addr[11:8] == 4'h0 && wo == abct_pkg::OFF_DERIVED) &&
                   q.aw_addr != abct_pkg::OFF_GSTAT) begin
        d.bresp = abct_pkg::RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // read channel: one outstanding read
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      {d.rresp, d.rdata} = rd_decode(s_axi_araddr, q);
    end
    // cycle sequencer
    case (q.st)
      abct_pkg::ST_IDLE: begin
        if (xfer_req) begin
          if (!hit_any) begin
            d.miss = 1'b1;
          end else begin
            d.bank = hit_idx;
            d.wr = xfer_write;
            if (xfer_write) begin
              len = wr_cyc[hit_idx];
            end else if (q.last_valid && !q.last_wr && q.last_bank == hit_idx &&
                         q.last_page == xfer_addr[31:4]) begin
              len = pg_cyc[hit_idx];
            end else begin
              len = rd_cyc[hit_idx];
            end
            d.act_len = (len == 8'h0) ? 8'h1 : len;
            if (q.last_valid && q.last_bank == hit_idx) begin
              gap = (!q.last_wr && xfer_write) ? r2w_cyc[hit_idx] :
                    (q.last_wr && !xfer_write) ? w2r_cyc[hit_idx] : 8'h0;
            end
            d.st = (gap != 8'h0) ? abct_pkg::ST_GAP : abct_pkg::ST_ACT;
            d.cnt = (gap != 8'h0) ? gap : d.act_len;
            d.last_valid = 1'b1;
            d.last_wr = xfer_write;
            d.last_bank = hit_idx;
            d.last_page = xfer_addr[31:4];
          end
        end
      end
      abct_pkg::ST_GAP: begin
        d.cnt = q.cnt - 8'h1;
        if (q.cnt == 8'h1) begin
          d.st = abct_pkg::ST_ACT;
          d.cnt = q.act_len;
        end
      end
      abct_pkg::ST_ACT: begin
        d.cnt = q.cnt - 8'h1;
        if (q.cnt == 8'h1) begin
          if (q.wr && rec_cyc[q.bank] != 8'h0) begin
            d.st = abct_pkg::ST_REC;
            d.cnt = rec_cyc[q.bank];
          end else begin
            d.st = abct_pkg::ST_IDLE;
            d.done = 1'b1;
          end
        end
      end
      abct_pkg::ST_REC: begin
        d.cnt = q.cnt - 8'h1;
        if (q.cnt == 8'h1) begin
          d.st = abct_pkg::ST_IDLE;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = abct_pkg::ST_IDLE;
      end
    endcase
    d.ce = (d.st == abct_pkg::ST_ACT) ? 4'(4'h1 << d.bank) : 4'h0;
    d.oe = (d.st == abct_pkg::ST_ACT) && !d.wr;
    d.we = (d.st == abct_pkg::ST_ACT) && d.wr;
    for (int i = 0; i < NB; i++) begin
      d.par[i] = q.cfg[i][abct_pkg::CFG_PARITY_BIT] &&
                 (kind[i] == abct_pkg::KIND_SYNC_SRAM || kind[i] == abct_pkg::KIND_ASYNC_SRAM);
    end
    d.neg = q.gctrl[0] && |sync_bank;
    // flash clock: high for the first ratio/2 cycles, rounded down, of each ratio-long period
    if (!ratio_ok || q.fdiv + 32'h1 >= ratio) begin
      d.fdiv = 32'h0;
    end else begin
      d.fdiv = q.fdiv + 32'h1;
    end
    d.fclk = ratio_ok && (d.fdiv < (ratio >> 1));
    // readies and busy are registered copies of what the next state implies
    d.awrdy = !d.aw_full && !d.bvalid;
    d.wrdy = !d.w_full && !d.bvalid;
    d.ardy = !d.rvalid;
    d.busy = d.st != abct_pkg::ST_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      for (int i = 0; i < NB; i++) begin
        q.cfg[i] <= abct_pkg::CFG_RESET;
      end
      q.flash_per <= abct_pkg::FLASH_PER_RESET;
      q.st <= abct_pkg::ST_IDLE;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.ardy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.ardy;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign xfer_busy = q.busy;
  assign xfer_done = q.done;
  assign xfer_miss = q.miss;
  assign bank_ce = q.ce;
  assign bank_oe = q.oe;
  assign bank_we = q.we;
  assign parity_check_en = q.par;
  assign falling_edge_io_flops = q.neg;
  assign flash_clk = q.fclk;
  assign memcfg_strobe = q.mstb;
  assign memcfg_data = q.mdata;
endmodule
`default_nettype wire

// ### verif/abct_mem_model.sv
/*
  abct_mem_model: far-side memory view of the bank strobes, recording the
  length and bank of the last active phase.
  Assumes active-high strobes sampled on the bus clock.
*/
`default_nettype none
module abct_mem_model (
  // clock
  input wire logic aclk,
  // strobes
  input wire logic [3:0] bank_ce,
  input wire logic bank_oe,
  input wire logic bank_we,
  // last access seen
  output logic [7:0] act_len,
  output logic [3:0] act_bank
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] run = 8'h00;
  // a device answers only while selected; length counts whole cycles
  always @(posedge aclk) begin
    if (bank_ce != 4'h0 && (bank_oe || bank_we)) begin
      run = run + 8'h01;
      act_len <= run;
      act_bank <= bank_ce;
    end else begin
      run = 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### verif/abct_bank_timing_monitor.sv
/*
  abct_bank_timing_monitor: concurrent checks on strobes, access pulses and
  bus responses. Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module abct_bank_timing_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus responses
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // access and strobes
  input wire logic xfer_done,
  input wire logic xfer_miss,
  input wire logic [3:0] bank_ce,
  input wire logic bank_oe,
  input wire logic bank_we,
  input wire logic [3:0] memcfg_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_CE_ONEHOT: assert property ($onehot0(bank_ce))
    else $error("more than one bank selected");
  AST_STROBE_CE: assert property ((bank_oe || bank_we) |-> bank_ce != 4'h0)
    else $error("strobe without chip select");
  AST_MISS_IDLE: assert property (xfer_miss |-> bank_ce == 4'h0 && $past(bank_ce) == 4'h0)
    else $error("bank selected on a miss");
  AST_CE_STEADY: assert property ((bank_ce != 4'h0 && $past(bank_ce) != 4'h0) |-> $stable(bank_ce))
    else $error("bank changed inside an access");
  AST_READ_END: assert property ($fell(bank_oe) |-> xfer_done)
    else $error("read ended without done");
  AST_WRITE_REC: assert property ($fell(bank_we) |-> ##[0:8] xfer_done)
    else $error("write recovery too long");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_CFG_PULSE: assert property (memcfg_strobe != 4'h0 |=> memcfg_strobe == 4'h0)
    else $error("config strobe longer than one cycle");
endmodule
bind abct_bank_timing abct_bank_timing_monitor u_mon (.*);
`default_nettype wire

// ### verif/tb.sv
/*
  tb: register and access tests for the bank cycle-timing block.
  Assumes the package constants and a 25 MHz bus clock.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, xfer_addr = 32'h0, s_axi_rdata, memcfg_data, d;
  logic [3:0] s_axi_wstrb = 4'hf, bank_ce, parity_check_en, memcfg_strobe, act_bank;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, xfer_req = 1'b0, xfer_write = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic xfer_busy, xfer_done, xfer_miss, bank_oe, bank_we, falling_edge_io_flops, flash_clk;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] act_len;
  logic [3:0] seen = 4'h0;
  int num_errors = 0, checks = 0, cyc = 0, n = 0;
  logic [43:0] tbl [28] = '{44'h000_00002101, 44'h004_000186a0, 44'h008_0000c350,
    44'h00c_0000a028, 44'h010_00002710, 44'h014_00009c40, 44'h018_00009c40,
    44'h01c_00015f90, 44'h020_00013880, 44'h024_00061a80, 44'h028_00000000,
    44'h02c_00000fff, 44'h040_00003020, 44'h044_00061a80, 44'h060_00013880,
    44'h068_00001000, 44'h06c_00001fff, 44'h080_00002103, 44'h084_0001d4c0,
    44'h094_00009c40, 44'h098_00009c40, 44'h0a4_00061a80, 44'h0a8_00002000,
    44'h0ac_00002fff, 44'h0e8_00003000, 44'h0ec_00003ffe, 44'h104_00013880,
    44'h100_00000000};
  abct_bank_timing u_dut (.*);
  abct_mem_model u_mem (.*);
  always #20 aclk = ~aclk;
  always @(posedge aclk) seen <= seen | memcfg_strobe;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb_;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb_ = 1'b0;
    while (!tb_) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb_ = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    // outputs launched at the response edge settle before callers look
    #1;
    chk({30'h0, rs}, {30'h0, abct_pkg::RESP_OKAY});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(v & m, e);
  endtask
  // expected: bank, gap, active and recovery cycles; active 0 means a miss
  task automatic acc(input logic wt, input logic [31:0] a, input logic [3:0] eb,
    input logic [7:0] eg, input logic [7:0] ea, input logic [7:0] er);
    logic [7:0] g, rc;
    logic m, s, bz;
    @(posedge aclk);
    xfer_req <= 1'b1;
    xfer_write <= wt;
    xfer_addr <= a;
    @(posedge aclk);
    xfer_req <= 1'b0;
    g = 8'h00;
    rc = 8'h00;
    s = 1'b0;
    bz = 1'b0;
    for (int k = 0; k < 600; k++) begin
      #1;
      m = xfer_miss === 1'b1;
      if (m || xfer_done === 1'b1) break;
      if (xfer_busy !== 1'b1) bz = 1'b1;
      if (bank_ce !== 4'h0) s = 1'b1;
      else if (s) rc++;
      else g++;
      @(posedge aclk);
    end
    chk({m ? 4'h0 : act_bank, 2'h0, bz, m, g, m ? 8'h00 : act_len, rc},
      {eb, 3'h0, ea == 8'h00, eg, ea, er});
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(12'h000, 32'hffff_ffff, 32'h0000_2001);
    rchk(12'h0c0, 32'hffff_ffff, 32'h0000_2001);
    rchk(12'h104, 32'hffff_ffff, 32'h0001_3880);
    w(12'h100, 32'h0000_0001);
    chk({31'h0, falling_edge_io_flops}, 32'h0);
    rchk(12'h108, 32'h00ff_037f, 32'h0002_022f);
    rd(12'h200, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, abct_pkg::RESP_SLVERR});
    wr(12'h1fc, 32'h1, r);
    chk({30'h0, r}, {30'h0, abct_pkg::RESP_SLVERR});
    $display("test reset and map done");
    foreach (tbl[i]) w(tbl[i][43:32], tbl[i][31:0]);
    rchk(12'h034, 32'hffff_ffff, 32'h0303_0202);
    rchk(12'h074, 32'hffff_ffff, 32'h0301_0000);
    chk({28'h0, parity_check_en}, 32'h1);
    chk({31'h0, falling_edge_io_flops}, 32'h0);
    rchk(12'h108, 32'h00ff_037f, 32'h0002_0348);
    w(12'h100, 32'h0000_0001);
    chk({31'h0, falling_edge_io_flops}, 32'h1);
    w(12'h104, 32'h0001_86a0);
    rchk(12'h108, 32'h0000_0010, 32'h0000_0010);
    w(12'h104, 32'h0001_d4c0);
    rchk(12'h108, 32'h00ff_0010, 32'h0003_0000);
    // a three-cycle flash clock is high one cycle in three
    repeat (6) begin
      @(posedge aclk);
      #1;
      n += flash_clk;
    end
    chk(n, 32'd2);
    w(12'h030, 32'h0000_00a5);
    chk(memcfg_data, 32'h0000_00a5);
    w(12'h070, 32'h0000_005a);
    w(12'h0b0, 32'h0000_0033);
    chk(memcfg_data, 32'h0000_005a);
    chk({28'h0, seen}, 32'h3);
    rchk(12'h030, 32'hffff_ffff, 32'h0);
    $display("test config done");
    acc(1'b0, 32'h0000_0000, 4'h1, 8'd0, 8'd3, 8'd0);
    acc(1'b0, 32'h0000_0004, 4'h1, 8'd0, 8'd3, 8'd0);
    acc(1'b1, 32'h0000_0008, 4'h1, 8'd2, 8'd3, 8'd0);
    acc(1'b0, 32'h0000_000c, 4'h1, 8'd2, 8'd3, 8'd0);
    acc(1'b0, 32'h0000_1000, 4'h2, 8'd0, 8'd3, 8'd0);
    acc(1'b1, 32'h0000_1004, 4'h2, 8'd0, 8'd1, 8'd0);
    acc(1'b0, 32'h0000_1008, 4'h2, 8'd0, 8'd3, 8'd0);
    acc(1'b0, 32'h0000_2000, 4'h4, 8'd0, 8'd3, 8'd0);
    acc(1'b0, 32'h0000_2004, 4'h4, 8'd0, 8'd1, 8'd0);
    acc(1'b1, 32'h0000_2010, 4'h4, 8'd0, 8'd1, 8'd8);
    acc(1'b0, 32'h0000_3000, 4'h0, 8'd0, 8'd0, 8'd0);
    acc(1'b0, 32'h0000_9000, 4'h0, 8'd0, 8'd0, 8'd0);
    $display("test access done");
    test_done();
  end
endmodule
`default_nettype wire
